// >>> logic/codec_pin_route_gpio_regs.v
// Pin routing and general pin value registers of the audio codec.
// Assumes all pin inputs are synchronous to ref_clk_in except the monitored general pins.
//
// What this block does
// [R1] Bidirectional pin drives stored bit 7 when configured as output.
// [R2] Output pin A drives stored bit 5 when configured as output.
// [R3] Bit 3 reads sampled bidirectional pin level while it is an input.
// [R4] Bit 2 reads sampled input pin B level while it is an input.
// [R5] Bit 1 reads sampled input pin A level while it is an input.
// [R6] Reserved bits are written as zero by software and read as zero.
// [R7] Auxiliary clock source: off, bidirectional pin, input pin B, input pin A.
// [R8] Second data input source: off, pins, serial out pin, primary data in.
// [R9] Primary bit clock from its own pin or from the secondary port.
// [R10] Primary frame sync from its own pin or from the secondary port.
// [R11] Serial out function resets to 5, primary data; 6 is second output.
// [R12] Codes 0 to 4: disabled, input, general output, interrupt, density clock.
// [R13] Code 9 drives secondary bit clock, code 10 the general clock.
// [R14] Code 12 muxed data, 13 daisy chain, 14 loopback, 15 reserved.
// [R15] General output function drives the stored serial out level bit.
// [R16] Drive field resets to 2 and selects one of six pad drive styles.
// [R17] Monitors are synchronised and read zero when the pin is no input.
`timescale 1ns/1ns
`include "codec_pin_route_regs.vh"

module codec_pin_route_gpio_regs (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // General pin configuration
  input wire bidir_pin_is_output_in,
  input wire bidir_pin_is_input_in,
  input wire out_pin_a_is_output_in,
  input wire in_pin_a_is_input_in,
  input wire in_pin_b_is_input_in,
  // General pins
  input wire bidir_general_pin_in,
  output reg bidir_general_pin_out,
  output reg bidir_general_pin_oe_out,
  output reg general_out_pin_a_out,
  output reg general_out_pin_a_oe_out,
  input wire general_in_pin_a_in,
  input wire general_in_pin_b_in,
  // Serial output pin
  input wire serial_out_pin_in,
  output reg serial_out_pin_out,
  output reg serial_out_pin_oe_out,
  // Sources for the serial output pin
  input wire primary_port_data_out_in,
  input wire primary_port_data_out2_in,
  input wire secondary_port_data_out_in,
  input wire secondary_port_data_out2_in,
  input wire chip_irq_in,
  input wire density_mod_clock_in,
  input wire general_clock_in,
  input wire daisy_chain_out_in,
  input wire mux_pick_secondary_in,
  // Primary port pins and secondary port sources
  input wire primary_port_data_in_in,
  input wire primary_port_bit_clock_pin_in,
  input wire primary_port_frame_sync_pin_in,
  input wire secondary_port_bit_clock_in,
  input wire secondary_port_frame_sync_in,
  // Routed signals
  output reg aux_clock_out,
  output reg primary_port_data_in2_out,
  output reg primary_port_bit_clock_out,
  output reg primary_port_frame_sync_out
);

  // ----------------------------------------------------------------
  // Source selection shared by the clock and data input selectors
  // ----------------------------------------------------------------
  function pick_general_pin;
    input [2:0] code;
    input bidir_level;
    input in_b_level;
    input in_a_level;
    begin
      case (code)
        `SRC_BIDIR: pick_general_pin = bidir_level;
        `SRC_IN_B: pick_general_pin = in_b_level;
        `SRC_IN_A: pick_general_pin = in_a_level;
        default: pick_general_pin = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg bidir_pin_out_level_q;
  reg out_pin_a_level_q;
  reg [1:0] aux_clock_source_q;
  reg [2:0] primary_port_data_in2_source_q;
  reg primary_port_bit_clock_source_q;
  reg primary_port_frame_sync_source_q;
  reg [3:0] serial_out_pin_function_q;
  reg serial_out_pin_level_q;
  reg [2:0] serial_out_pin_drive_q;

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bidir_pin_out_level_q <= `RST_BIT;
      out_pin_a_level_q <= `RST_BIT;
      aux_clock_source_q <= 2'h0;
      primary_port_data_in2_source_q <= `SRC_OFF;
      primary_port_bit_clock_source_q <= `RST_BIT;
      primary_port_frame_sync_source_q <= `RST_BIT;
      serial_out_pin_function_q <= `RST_OUT_PIN_FUNC; // R11
      serial_out_pin_level_q <= `RST_BIT;
      serial_out_pin_drive_q <= `RST_OUT_PIN_DRIVE; // R16
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ADDR_PIN_LEVEL_VALUE: begin
          bidir_pin_out_level_q <= reg_wdata_in[`BIT_BIDIR_OUT_LEVEL];
          out_pin_a_level_q <= reg_wdata_in[`BIT_OUT_A_LEVEL];
        end
        `ADDR_PORT_ROUTE_CFG: begin
          aux_clock_source_q <= reg_wdata_in[`AUX_CLK_HI:`AUX_CLK_LO];
          primary_port_data_in2_source_q <= reg_wdata_in[`DIN2_SRC_HI:`DIN2_SRC_LO];
          primary_port_bit_clock_source_q <= reg_wdata_in[`BIT_BCLK_SRC];
          primary_port_frame_sync_source_q <= reg_wdata_in[`BIT_FSYNC_SRC];
        end
        `ADDR_OUT_PIN_CFG: begin
          serial_out_pin_function_q <= reg_wdata_in[`OUT_FUNC_HI:`OUT_FUNC_LO];
          serial_out_pin_level_q <= reg_wdata_in[`BIT_OUT_LEVEL];
          serial_out_pin_drive_q <= reg_wdata_in[`OUT_DRIVE_HI:`OUT_DRIVE_LO];
        end
        default: begin
          bidir_pin_out_level_q <= bidir_pin_out_level_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input monitors
  // ----------------------------------------------------------------
  wire [`MON_WIDTH-1:0] mon_raw;
  wire [`MON_WIDTH-1:0] mon_sync;
  wire bidir_pin_in_level;
  wire in_pin_b_level;
  wire in_pin_a_level;

  assign mon_raw = {bidir_general_pin_in, general_in_pin_b_in, general_in_pin_a_in};

  monitor_sync u_monitor_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .raw_in(mon_raw),
    .sync_out(mon_sync)
  );

  assign bidir_pin_in_level = mon_sync[`MON_BIDIR] & bidir_pin_is_input_in; // R3 R17
  assign in_pin_b_level = mon_sync[`MON_IN_B] & in_pin_b_is_input_in; // R4 R17
  assign in_pin_a_level = mon_sync[`MON_IN_A] & in_pin_a_is_input_in; // R5 R17

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  reg [7:0] read_value;

  always @* begin
    read_value = 8'h00; // R6
    case (reg_addr_in)
      `ADDR_PIN_LEVEL_VALUE: begin
        read_value[`BIT_BIDIR_OUT_LEVEL] = bidir_pin_out_level_q;
        read_value[`BIT_OUT_A_LEVEL] = out_pin_a_level_q;
        read_value[`BIT_BIDIR_IN_LEVEL] = bidir_pin_in_level; // R3
        read_value[`BIT_IN_B_LEVEL] = in_pin_b_level; // R4
        read_value[`BIT_IN_A_LEVEL] = in_pin_a_level; // R5
      end
      `ADDR_PORT_ROUTE_CFG: begin
        read_value[`AUX_CLK_HI:`AUX_CLK_LO] = aux_clock_source_q;
        read_value[`DIN2_SRC_HI:`DIN2_SRC_LO] = primary_port_data_in2_source_q;
        read_value[`BIT_BCLK_SRC] = primary_port_bit_clock_source_q;
        read_value[`BIT_FSYNC_SRC] = primary_port_frame_sync_source_q;
      end
      `ADDR_OUT_PIN_CFG: begin
        read_value[`OUT_FUNC_HI:`OUT_FUNC_LO] = serial_out_pin_function_q;
        read_value[`BIT_OUT_LEVEL] = serial_out_pin_level_q;
        read_value[`OUT_DRIVE_HI:`OUT_DRIVE_LO] = serial_out_pin_drive_q;
      end
      default: begin
        read_value = 8'h00;
      end
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= read_value;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Input routing
  // ----------------------------------------------------------------
  reg aux_clock_d;
  reg primary_port_data_in2_d;
  reg primary_port_bit_clock_d;
  reg primary_port_frame_sync_d;

  always @* begin
    aux_clock_d = pick_general_pin({1'b0, aux_clock_source_q}, bidir_general_pin_in,
      general_in_pin_b_in, general_in_pin_a_in); // R7
    case (primary_port_data_in2_source_q)
      `SRC_SERIAL_OUT: primary_port_data_in2_d = serial_out_pin_in; // R8
      `SRC_PRIMARY_DIN: primary_port_data_in2_d = primary_port_data_in_in; // R8
      default: primary_port_data_in2_d = pick_general_pin(primary_port_data_in2_source_q,
        bidir_general_pin_in, general_in_pin_b_in, general_in_pin_a_in); // R8
    endcase
    if (primary_port_bit_clock_source_q) begin
      primary_port_bit_clock_d = secondary_port_bit_clock_in; // R9
    end else begin
      primary_port_bit_clock_d = primary_port_bit_clock_pin_in; // R9
    end
    if (primary_port_frame_sync_source_q) begin
      primary_port_frame_sync_d = secondary_port_frame_sync_in; // R10
    end else begin
      primary_port_frame_sync_d = primary_port_frame_sync_pin_in; // R10
    end
  end

  // ----------------------------------------------------------------
  // Serial output pin function
  // ----------------------------------------------------------------
  reg serial_level_d;
  reg serial_active_d;
  wire serial_pin_d;
  wire serial_oe_d;

  always @* begin
    serial_active_d = 1'b1;
    case (serial_out_pin_function_q)
      `FUNC_GPO: serial_level_d = serial_out_pin_level_q; // R12 R15
      `FUNC_IRQ: serial_level_d = chip_irq_in; // R12
      `FUNC_DMCLK: serial_level_d = density_mod_clock_in; // R12
      `FUNC_PRI_DOUT: serial_level_d = primary_port_data_out_in; // R11
      `FUNC_PRI_DOUT2: serial_level_d = primary_port_data_out2_in; // R11
      `FUNC_SEC_DOUT: serial_level_d = secondary_port_data_out_in;
      `FUNC_SEC_DOUT2: serial_level_d = secondary_port_data_out2_in;
      `FUNC_SEC_BCLK: serial_level_d = secondary_port_bit_clock_in; // R13
      `FUNC_GEN_CLK: serial_level_d = general_clock_in; // R13
      `FUNC_MUXED: begin
        if (mux_pick_secondary_in) begin
          serial_level_d = secondary_port_data_out_in; // R14
        end else begin
          serial_level_d = primary_port_data_out_in; // R14
        end
      end
      `FUNC_DAISY: serial_level_d = daisy_chain_out_in; // R14
      `FUNC_LOOPBACK: serial_level_d = primary_port_data_in_in; // R14
      default: begin
        serial_level_d = 1'b0; // R12 R14
        serial_active_d = 1'b0;
      end
    endcase
  end

  out_pin_drive u_out_pin_drive (
    .active_in(serial_active_d),
    .level_in(serial_level_d),
    .drive_in(serial_out_pin_drive_q),
    .pin_out(serial_pin_d),
    .pin_oe_out(serial_oe_d)
  );

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bidir_general_pin_out <= 1'b0;
      bidir_general_pin_oe_out <= 1'b0;
      general_out_pin_a_out <= 1'b0;
      general_out_pin_a_oe_out <= 1'b0;
      serial_out_pin_out <= 1'b0;
      serial_out_pin_oe_out <= 1'b0;
      aux_clock_out <= 1'b0;
      primary_port_data_in2_out <= 1'b0;
      primary_port_bit_clock_out <= 1'b0;
      primary_port_frame_sync_out <= 1'b0;
    end else begin
      bidir_general_pin_out <= bidir_pin_out_level_q & bidir_pin_is_output_in; // R1
      bidir_general_pin_oe_out <= bidir_pin_is_output_in; // R1
      general_out_pin_a_out <= out_pin_a_level_q & out_pin_a_is_output_in; // R2
      general_out_pin_a_oe_out <= out_pin_a_is_output_in; // R2
      serial_out_pin_out <= serial_pin_d; // R16
      serial_out_pin_oe_out <= serial_oe_d; // R16
      aux_clock_out <= aux_clock_d;
      primary_port_data_in2_out <= primary_port_data_in2_d;
      primary_port_bit_clock_out <= primary_port_bit_clock_d;
      primary_port_frame_sync_out <= primary_port_frame_sync_d;
    end
  end

endmodule

// >>> logic/codec_pin_route_regs.vh
// Register map, field positions, reset values and select codes for the pin routing block.
// Assumes it is included by bare name from every design file that needs these names.
`ifndef CODEC_PIN_ROUTE_REGS_VH
`define CODEC_PIN_ROUTE_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_PIN_LEVEL_VALUE 8'h0e
`define ADDR_PORT_ROUTE_CFG 8'h0f
`define ADDR_OUT_PIN_CFG 8'h10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PIN_LEVEL_VALUE 8'h00
`define RST_PORT_ROUTE_CFG 8'h00
`define RST_OUT_PIN_CFG 8'h52
`define RST_OUT_PIN_FUNC 4'h5
`define RST_OUT_PIN_DRIVE 3'h2
`define RST_BIT 1'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_BIDIR_OUT_LEVEL 7
`define BIT_OUT_A_LEVEL 5
`define BIT_BIDIR_IN_LEVEL 3
`define BIT_IN_B_LEVEL 2
`define BIT_IN_A_LEVEL 1
`define AUX_CLK_HI 6
`define AUX_CLK_LO 5
`define DIN2_SRC_HI 4
`define DIN2_SRC_LO 2
`define BIT_BCLK_SRC 1
`define BIT_FSYNC_SRC 0
`define OUT_FUNC_HI 7
`define OUT_FUNC_LO 4
`define BIT_OUT_LEVEL 3
`define OUT_DRIVE_HI 2
`define OUT_DRIVE_LO 0
`define MON_WIDTH 3
`define MON_BIDIR 2
`define MON_IN_B 1
`define MON_IN_A 0

// ----------------------------------------------------------------
// Source select codes; the clock selector uses 0 to 3, the data input selector all six
// ----------------------------------------------------------------
`define SRC_OFF 3'h0
`define SRC_BIDIR 3'h1
`define SRC_IN_B 3'h2
`define SRC_IN_A 3'h3
`define SRC_SERIAL_OUT 3'h4
`define SRC_PRIMARY_DIN 3'h5

// ----------------------------------------------------------------
// Serial output pin function codes
// ----------------------------------------------------------------
`define FUNC_DISABLED 4'h0
`define FUNC_INPUT 4'h1
`define FUNC_GPO 4'h2
`define FUNC_IRQ 4'h3
`define FUNC_DMCLK 4'h4
`define FUNC_PRI_DOUT 4'h5
`define FUNC_PRI_DOUT2 4'h6
`define FUNC_SEC_DOUT 4'h7
`define FUNC_SEC_DOUT2 4'h8
`define FUNC_SEC_BCLK 4'h9
`define FUNC_GEN_CLK 4'ha
`define FUNC_MUXED 4'hc
`define FUNC_DAISY 4'hd
`define FUNC_LOOPBACK 4'he

// ----------------------------------------------------------------
// Serial output pin drive codes
// ----------------------------------------------------------------
`define DRV_HIZ 3'h0
`define DRV_PUSH_PULL 3'h1
`define DRV_LOW_WEAK_HIGH 3'h2
`define DRV_LOW_ONLY 3'h3
`define DRV_WEAK_LOW_HIGH 3'h4
`define DRV_HIGH_ONLY 3'h5

`endif

// >>> logic/monitor_sync.v
// Two-stage synchroniser for the general pin input monitors.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`include "codec_pin_route_regs.vh"

module monitor_sync (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Raw and synchronised levels
  input wire [`MON_WIDTH-1:0] raw_in,
  output wire [`MON_WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `MON_WIDTH; i = i + 1) begin : g_sync
      reg meta_q;
      reg stable_q;
      always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q <= `RST_BIT;
          stable_q <= `RST_BIT;
        end else begin
          meta_q <= raw_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule

// >>> logic/out_pin_drive.v
// Drive encoder for the serial output pin: level and drive code to out and enable.
// Assumes the caller registers both results; weak pulls are left to the pad.
`timescale 1ns/1ns
`include "codec_pin_route_regs.vh"

module out_pin_drive (
  // Request
  input wire active_in,
  input wire level_in,
  input wire [2:0] drive_in,
  // Pad control
  output reg pin_out,
  output reg pin_oe_out
);

  // ----------------------------------------------------------------
  // Drive decode
  // ----------------------------------------------------------------
  always @* begin
    pin_out = 1'b0;
    pin_oe_out = 1'b0;
    if (active_in) begin
      case (drive_in)
        `DRV_PUSH_PULL: begin
          pin_out = level_in;
          pin_oe_out = 1'b1;
        end
        `DRV_LOW_WEAK_HIGH, `DRV_LOW_ONLY: begin
          pin_out = 1'b0;
          pin_oe_out = ~level_in;
        end
        `DRV_WEAK_LOW_HIGH, `DRV_HIGH_ONLY: begin
          pin_out = 1'b1;
          pin_oe_out = level_in;
        end
        default: begin
          pin_out = 1'b0;
          pin_oe_out = 1'b0;
        end
      endcase
    end
  end

endmodule

// >>> test/codec_pin_route_props.sv
// Checker for the pin routing block, seeing only its top module ports.
// Assumes the register map header is on the include path.
`timescale 1ns/1ns
`include "codec_pin_route_regs.vh"

module codec_pin_route_props (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // Pin configuration
  input wire bidir_pin_is_output_in,
  input wire bidir_pin_is_input_in,
  input wire out_pin_a_is_output_in,
  input wire in_pin_a_is_input_in,
  input wire in_pin_b_is_input_in,
  // Pins and routes
  input wire bidir_general_pin_out,
  input wire bidir_general_pin_oe_out,
  input wire general_out_pin_a_out,
  input wire general_out_pin_a_oe_out,
  input wire serial_out_pin_out,
  input wire serial_out_pin_oe_out,
  input wire primary_port_bit_clock_pin_in,
  input wire primary_port_frame_sync_pin_in,
  input wire secondary_port_bit_clock_in,
  input wire secondary_port_frame_sync_in,
  input wire primary_port_bit_clock_out,
  input wire primary_port_frame_sync_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_bidir_oe_follow: assert property (
    $past(rst_n_in) |-> bidir_general_pin_oe_out == $past(bidir_pin_is_output_in))
    else $error("bidir enable wrong");
  a_bidir_value_gate: assert property (
    bidir_general_pin_out |-> bidir_general_pin_oe_out)
    else $error("bidir high undriven");
  a_pin_a_oe_follow: assert property (
    $past(rst_n_in) |-> general_out_pin_a_oe_out == $past(out_pin_a_is_output_in))
    else $error("pin a enable wrong");
  a_pin_a_value_gate: assert property (
    general_out_pin_a_out |-> general_out_pin_a_oe_out)
    else $error("pin a high undriven");
  a_level_reserved_zero: assert property (
    reg_rd_in && reg_addr_in == `ADDR_PIN_LEVEL_VALUE |=> (reg_rdata_out & 8'h51) == 8'h00)
    else $error("level reserved bits set");
  a_route_reserved_zero: assert property (
    reg_rd_in && reg_addr_in == `ADDR_PORT_ROUTE_CFG |=> reg_rdata_out[7] == 1'b0)
    else $error("route reserved bit set");
  a_monitor_gate_zero: assert property (
    reg_rd_in && reg_addr_in == `ADDR_PIN_LEVEL_VALUE |=> (reg_rdata_out[3:1] &
    ~$past({bidir_pin_is_input_in, in_pin_b_is_input_in, in_pin_a_is_input_in})) == 3'h0)
    else $error("monitor set for non-input");
  a_bclk_route: assert property (
    reg_wr_in && reg_addr_in == `ADDR_PORT_ROUTE_CFG |=> ##1 primary_port_bit_clock_out ==
    ($past(reg_wdata_in[1], 2) ? $past(secondary_port_bit_clock_in)
    : $past(primary_port_bit_clock_pin_in)))
    else $error("bit clock wrong source");
  a_fsync_route: assert property (
    reg_wr_in && reg_addr_in == `ADDR_PORT_ROUTE_CFG |=> ##1 primary_port_frame_sync_out ==
    ($past(reg_wdata_in[0], 2) ? $past(secondary_port_frame_sync_in)
    : $past(primary_port_frame_sync_pin_in)))
    else $error("frame sync wrong source");
  a_gpo_drive_level: assert property (
    reg_wr_in && reg_addr_in == `ADDR_OUT_PIN_CFG && reg_wdata_in[7:4] == 4'h2 &&
    reg_wdata_in[2:0] == 3'h1 |=> ##1 serial_out_pin_oe_out &&
    serial_out_pin_out == $past(reg_wdata_in[3], 2))
    else $error("serial pin level wrong");
  a_disabled_no_drive: assert property (
    reg_wr_in && reg_addr_in == `ADDR_OUT_PIN_CFG && reg_wdata_in[7:4] == 4'h0
    |=> ##1 !serial_out_pin_oe_out && !serial_out_pin_out)
    else $error("disabled pin driven");
endmodule

bind codec_pin_route_gpio_regs codec_pin_route_props u_props (.*);

// >>> test/audio_host_model.sv
// Model of the external audio host driving the primary serial port pins.
// Assumes it shares the block clock; idle data line changes every cycle.
`timescale 1ns/1ns

module audio_host_model (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Control
  input wire run_in,
  // Primary serial port pins
  output reg bit_clock_out,
  output reg frame_sync_out,
  output reg data_out
);
  reg [3:0] cnt_q;

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h0;
      bit_clock_out <= 1'b0;
      frame_sync_out <= 1'b0;
      data_out <= 1'b0;
    end else if (run_in) begin
      cnt_q <= cnt_q + 4'h1;
      bit_clock_out <= ~bit_clock_out;
      frame_sync_out <= (cnt_q == 4'h0);
      data_out <= cnt_q[1] ^ cnt_q[3];
    end else begin
      bit_clock_out <= 1'b0;
      frame_sync_out <= 1'b0;
      data_out <= ~data_out;
    end
  end
endmodule

// >>> test/codec_pin_route_gpio_regs_tb.sv
// Self-checking testbench for the pin routing block.
// Assumes the host model drives the primary port pins and the bench all others.
`timescale 1ns/1ns
`include "codec_pin_route_regs.vh"

module codec_pin_route_gpio_regs_tb;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [4:0] cfg = 5'h00;
  reg [14:0] pat = 15'h0000;
  reg hold = 1'b0;
  reg [2:0] mon_pat = 3'h0;
  reg run = 1'b0;
  reg [19:0] snap = 20'h00000;
  reg [7:0] r_lvl = 8'h00;
  reg [7:0] r_route = 8'h00;
  reg [7:0] r_out = 8'h52;
  integer error_cnt = 0;
  integer checked = 0;
  wire [7:0] rdata;
  wire pdin, pbclk, pfsync, bo, boe, ao, aoe, so, soe, aux, din2, pbo, pfo;

  always #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    pat <= hold ? {12'h000, mon_pat} : pat + 15'h0001;
    snap <= {pfsync, pbclk, pdin, cfg[4], cfg[3], pat};
  end

  audio_host_model host (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .run_in(run),
    .bit_clock_out(pbclk), .frame_sync_out(pfsync), .data_out(pdin));

  codec_pin_route_gpio_regs dut (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .bidir_pin_is_output_in(cfg[3]), .bidir_pin_is_input_in(cfg[0]),
    .out_pin_a_is_output_in(cfg[4]), .in_pin_a_is_input_in(cfg[1]),
    .in_pin_b_is_input_in(cfg[2]), .bidir_general_pin_in(pat[0]),
    .bidir_general_pin_out(bo), .bidir_general_pin_oe_out(boe), .general_out_pin_a_out(ao),
    .general_out_pin_a_oe_out(aoe), .general_in_pin_a_in(pat[2]),
    .general_in_pin_b_in(pat[1]), .serial_out_pin_in(pat[3]), .serial_out_pin_out(so),
    .serial_out_pin_oe_out(soe), .primary_port_data_out_in(pat[6]),
    .primary_port_data_out2_in(pat[7]), .secondary_port_data_out_in(pat[8]),
    .secondary_port_data_out2_in(pat[9]), .chip_irq_in(pat[10]),
    .density_mod_clock_in(pat[11]), .general_clock_in(pat[12]),
    .daisy_chain_out_in(pat[13]), .mux_pick_secondary_in(pat[14]),
    .primary_port_data_in_in(pdin), .primary_port_bit_clock_pin_in(pbclk),
    .primary_port_frame_sync_pin_in(pfsync), .secondary_port_bit_clock_in(pat[4]),
    .secondary_port_frame_sync_in(pat[5]), .aux_clock_out(aux),
    .primary_port_data_in2_out(din2), .primary_port_bit_clock_out(pbo),
    .primary_port_frame_sync_out(pfo));

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask

  task chk(input string name, input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
      if (a == `ADDR_PIN_LEVEL_VALUE) r_lvl = d & 8'ha0;
      if (a == `ADDR_PORT_ROUTE_CFG) r_route = d & 8'h7f;
      if (a == `ADDR_OUT_PIN_CFG) r_out = d;
    end
  endtask

  task rd_reg(input [7:0] a, input [7:0] exp);
    begin
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      chk("read_data", rdata, exp);
    end
  endtask

  function src(input [2:0] c);
    src = (c == 3'h0 || c > 3'h5) ? 1'b0 : c == 3'h5 ? snap[17] : snap[c - 3'h1];
  endfunction

  task check_pins(input integer n);
    integer i;
    reg lvl, act, o, e;
    begin
      @(posedge ref_clk);
      for (i = 0; i < n; i = i + 1) begin
        @(negedge ref_clk);
        chk("bidir_pin", {6'h00, bo, boe}, {6'h00, r_lvl[7] & snap[15], snap[15]});
        chk("pin_a", {6'h00, ao, aoe}, {6'h00, r_lvl[5] & snap[16], snap[16]});
        chk("aux_clock", {7'h00, aux}, {7'h00, src({1'b0, r_route[6:5]})});
        chk("data_in2", {7'h00, din2}, {7'h00, src(r_route[4:2])});
        chk("bit_clock", {7'h00, pbo}, {7'h00, r_route[1] ? snap[4] : snap[18]});
        chk("frame_sync", {7'h00, pfo}, {7'h00, r_route[0] ? snap[5] : snap[19]});
        lvl = 1'b0;
        act = 1'b1;
        case (r_out[7:4])
          4'h2: lvl = r_out[3];
          4'h3: lvl = snap[10];
          4'h4: lvl = snap[11];
          4'h5: lvl = snap[6];
          4'h6: lvl = snap[7];
          4'h7: lvl = snap[8];
          4'h8: lvl = snap[9];
          4'h9: lvl = snap[4];
          4'ha: lvl = snap[12];
          4'hc: lvl = snap[14] ? snap[8] : snap[6];
          4'hd: lvl = snap[13];
          4'he: lvl = snap[17];
          default: act = 1'b0;
        endcase
        case (r_out[2:0])
          3'h1: {o, e} = {lvl, 1'b1};
          3'h2, 3'h3: {o, e} = {1'b0, ~lvl};
          3'h4, 3'h5: {o, e} = {1'b1, lvl};
          default: {o, e} = 2'b00;
        endcase
        if (!act) {o, e} = 2'b00;
        chk("serial_pin", {6'h00, so, soe}, {6'h00, o, e});
      end
      @(posedge ref_clk);
    end
  endtask

  task t_reset;
    begin
      rd_reg(`ADDR_PIN_LEVEL_VALUE, `RST_PIN_LEVEL_VALUE);
      rd_reg(`ADDR_PORT_ROUTE_CFG, `RST_PORT_ROUTE_CFG);
      rd_reg(`ADDR_OUT_PIN_CFG, `RST_OUT_PIN_CFG);
      check_pins(2);
      wr_reg(8'h11, 8'hff);
      rd_reg(8'h11, 8'h00);
      rd_reg(`ADDR_PIN_LEVEL_VALUE, 8'h00);
    end
  endtask

  task t_route;
    integer i;
    begin
      run <= 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        wr_reg(`ADDR_PIN_LEVEL_VALUE, {i[0], 1'b0, i[1], 5'h00});
        cfg <= {i[2], ~i[2], 3'b000};
        wr_reg(`ADDR_PORT_ROUTE_CFG, {1'b0, i[1:0], i[2:0], i[0], ~i[1]});
        rd_reg(`ADDR_PORT_ROUTE_CFG, {1'b0, i[1:0], i[2:0], i[0], ~i[1]});
        check_pins(4);
      end
    end
  endtask

  task t_serial;
    integer j;
    begin
      cfg <= 5'h18;
      for (j = 0; j < 128; j = j + 1) begin
        wr_reg(`ADDR_OUT_PIN_CFG, {j[6:3], j[0] ^ j[3], j[2:0]});
        check_pins(3);
      end
    end
  endtask

  task t_mon;
    integer k;
    begin
      hold <= 1'b1;
      for (k = 2; k < 6; k = k + 3) begin
        @(posedge ref_clk);
        mon_pat <= k[2:0];
        cfg <= 5'h07;
        repeat (3) @(posedge ref_clk);
        rd_reg(`ADDR_PIN_LEVEL_VALUE, {r_lvl[7], 1'b0, r_lvl[5], 1'b0, k[0], k[1], k[2], 1'b0});
        @(posedge ref_clk) cfg <= 5'h00;
        rd_reg(`ADDR_PIN_LEVEL_VALUE, {r_lvl[7], 1'b0, r_lvl[5], 5'h00});
      end
    end
  endtask

  initial begin
    #500000;
    error_cnt = error_cnt + 1;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_sim;
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_route;
    t_serial;
    t_mon;
    end_sim;
  end
endmodule
